/* File: design/swf_byte_fifo.sv */
// byte fifo between the sequencer and the read slots
`timescale 1ns/1ps
`default_nettype none
module swf_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = store[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // pointers and fill level; flush drops everything queued
  always_ff @(posedge clk) begin
    if (!resetn || (clkEn && flush)) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (clkEn) begin
      if (push) wrPtr <= AW'(wrPtr + 1'b1);
      if (pop) rdPtr <= AW'(rdPtr + 1'b1);
      count <= (AW+1)'(count + push - pop);
    end
  end

  // storage array
  always_ff @(posedge clk) begin
    if (clkEn && push) begin
      store[wrPtr] <= inData;
    end
  end
endmodule
`default_nettype wire

/* File: design/swf_function_sequencer.sv */
// function-command sequencer of a single-wire slave with memory and i/o pins
`timescale 1ns/1ps
`default_nettype none
module swf_function_sequencer
  import swf_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic busReset,
  input wire swf_byte_t rxByte,
  output swf_byte_t txByte,
  input wire logic txTake,
  output logic txReady,
  input wire logic lineHigh,
  output logic slotStart,
  input wire logic [55:0] romId,
  output logic [63:0] romCode,
  input wire logic copyProtect,
  input wire logic [7:0] pioPins,
  output logic [7:0] pioOut
);
  // ----------------------------------------
  // state and storage
  // ----------------------------------------
  typedef enum logic [4:0] {
    S_CMD, S_TA1, S_TA2, S_ES, S_WS, S_RSH, S_DATA, S_CRCL, S_CRCH,
    S_REG, S_IOR, S_IOW1, S_IOW2, S_IOWA, S_IOWP, S_PROG, S_FF, S_AA
  } swf_state_t;

  swf_state_t st;
  logic [7:0] cmd;
  logic [15:0] ta;
  logic [15:0] spTa;
  logic [9:0] off;
  logic [1:0] hdr;
  logic [5:0] blkCnt;
  logic iorLoop;
  logic [7:0] ioNew;
  logic [17:0] progCnt;
  logic [15:0] crc;
  logic [4:0] endOff;
  logic pf;
  logic aaFlag;
  logic [7:0] spad [0:31];
  logic [7:0] mem [0:MEM_WORDS-1];
  logic filtHigh;
  logic [7:0] holdCnt;
  logic [7:0] glCnt;
  logic [7:0] rx;
  logic rxGo;
  logic txPush;
  logic txRdy;
  logic txGo;
  logic [7:0] txData;
  logic [7:0] esByte;
  logic copyOk;
  logic fifoValid;
  logic [7:0] fifoData;

  assign rx = rxByte.data;
  assign esByte = {aaFlag, 1'b0, pf, endOff};
  // a copy needs the exact address and status, a whole write and open memory
  assign copyOk = (ta == spTa) && (rx == esByte) && !pf && !copyProtect
    && (spTa <= MEM_LAST);

  // ----------------------------------------
  // byte handshakes
  // ----------------------------------------
  always_comb begin
    rxGo = 1'b0;
    if (clkEn && rxByte.valid && !busReset) begin
      rxGo = (st == S_CMD) || (st == S_TA1) || (st == S_TA2) || (st == S_ES)
        || (st == S_WS) || (st == S_REG) || (st == S_IOW1) || (st == S_IOW2);
    end
  end

  // byte offered to the read slots in each talking state
  always_comb begin
    txPush = 1'b1;
    txData = FILL_FF;
    unique case (st)
      S_RSH: txData = (hdr == 2'd0) ? ta[7:0] : (hdr == 2'd1) ? ta[15:8] : esByte;
      S_DATA: txData = (cmd == SCRATCH_READ_CMD) ? spad[off[4:0]] : mem[off];
      S_CRCL: txData = ~crc[7:0];
      S_CRCH: txData = ~crc[15:8];
      S_IOR: txData = pioPins;
      S_IOWA: txData = FILL_AA;
      S_IOWP: txData = pioPins;
      S_AA: txData = FILL_AA;
      S_FF: txData = FILL_FF;
      default: txPush = 1'b0;
    endcase
  end
  assign txGo = clkEn && !busReset && txPush && txRdy;

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  // bus reset abandons any sequence, including the endless filler loops
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st <= S_CMD;
      cmd <= 8'h00;
      ta <= 16'h0000;
      off <= 10'h000;
      hdr <= 2'd0;
      blkCnt <= 6'h00;
      iorLoop <= 1'b0;
      ioNew <= 8'h00;
      progCnt <= 18'h0_0000;
    end else if (clkEn) begin
      if (busReset) begin
        st <= S_CMD;
      end else begin
        unique case (st)
          S_CMD: if (rxGo) begin
            cmd <= rx;
            hdr <= 2'd0;
            blkCnt <= 6'h00;
            ta <= spTa;
            if (rx == SCRATCH_READ_CMD) st <= S_RSH;
            else if (rx == IO_READ_CMD) st <= S_IOR;
            else if (rx == IO_WRITE_CMD) st <= S_IOW1;
            else if (rx == SCRATCH_WRITE_CMD || rx == SCRATCH_COPY_CMD
              || rx == MEMORY_READ_CMD || rx == REGISTER_WRITE_CMD) st <= S_TA1;
            else st <= S_FF;
          end
          S_TA1: if (rxGo) begin
            ta[7:0] <= rx;
            st <= S_TA2;
          end
          S_TA2: if (rxGo) begin
            ta[15:8] <= rx;
            off <= {rx[1:0], ta[7:0]};
            if (cmd == SCRATCH_WRITE_CMD) st <= S_WS;
            else if (cmd == SCRATCH_COPY_CMD) st <= S_ES;
            else if (cmd == MEMORY_READ_CMD)
              st <= ({rx, ta[7:0]} <= MEM_LAST) ? S_DATA : S_FF;
            else
              st <= ({rx, ta[7:0]} >= REG_FIRST && {rx, ta[7:0]} <= REG_LAST)
                ? S_REG : S_FF;
          end
          S_ES: if (rxGo) begin
            progCnt <= 18'h0_0000;
            st <= copyOk ? S_PROG : S_FF;
          end
          S_PROG: begin
            progCnt <= 18'(progCnt + 1'b1);
            if (progCnt == 18'(PROG_CYCLES - 1)) st <= S_AA;
          end
          S_WS: if (rxGo) begin
            off <= 10'(off + 1'b1);
            if (off[4:0] == SCRATCH_LAST) st <= S_CRCL;
          end
          S_RSH: if (txGo) begin
            hdr <= 2'(hdr + 1'b1);
            off <= {5'h00, spTa[4:0]};
            if (hdr == 2'd2) st <= S_DATA;
          end
          S_DATA: if (txGo) begin
            off <= 10'(off + 1'b1);
            if (cmd == SCRATCH_READ_CMD && off[4:0] == endOff) st <= S_CRCL;
            else if (cmd != SCRATCH_READ_CMD && off == MEM_LAST[9:0]) st <= S_FF;
          end
          S_REG: if (rxGo) begin
            off <= 10'(off + 1'b1);
            if (off == REG_LAST[9:0]) st <= S_FF;
          end
          S_CRCL: if (txGo) st <= S_CRCH;
          S_CRCH: if (txGo) st <= iorLoop ? S_IOR : S_FF;
          S_IOR: if (txGo) begin
            blkCnt <= 6'(blkCnt + 1'b1);
            if (blkCnt == IO_BLOCK_LAST) begin
              blkCnt <= 6'h00;
              st <= S_CRCL;
            end
          end
          S_IOW1: if (rxGo) begin
            ioNew <= rx;
            st <= S_IOW2;
          end
          S_IOW2: if (rxGo) st <= (rx == ~ioNew) ? S_IOWA : S_FF;
          S_IOWA: if (txGo) st <= S_IOWP;
          S_IOWP: if (txGo) st <= S_IOW1;
          S_FF, S_AA: st <= st;
        endcase
      end
      // io read loops through checksum blocks until bus reset
      iorLoop <= !busReset && (rxGo && st == S_CMD ? rx == IO_READ_CMD : iorLoop);
    end
  end

  // ----------------------------------------
  // transfer checksum
  // ----------------------------------------
  // cleared at each command; io read restarts it per block without the command
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      crc <= CRC16_INIT;
    end else if (clkEn && !busReset) begin
      if (st == S_CMD && rxGo) crc <= swf_crc16(CRC16_INIT, rx);
      else if (rxGo && (st == S_TA1 || st == S_TA2 || st == S_WS)) crc <= swf_crc16(crc, rx);
      else if (txGo && (st == S_RSH || st == S_IOR)) crc <= swf_crc16(crc, txData);
      else if (txGo && st == S_DATA && cmd == SCRATCH_READ_CMD) crc <= swf_crc16(crc, txData);
      else if (txGo && st == S_CRCH) crc <= CRC16_INIT;
    end
  end

  // ----------------------------------------
  // scratchpad, memory and pins
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      spTa <= 16'h0000;
      endOff <= 5'h00;
      pf <= 1'b0;
      aaFlag <= 1'b0;
      pioOut <= 8'hFF;
    end else if (clkEn && !busReset) begin
      if (st == S_TA2 && rxGo && cmd == SCRATCH_WRITE_CMD) begin
        spTa <= {rx, ta[7:0]};
        endOff <= ta[4:0];
        pf <= 1'b1; // no data yet: a copy now would be partial
        aaFlag <= 1'b0;
      end
      if (st == S_WS && rxGo) begin
        spad[off[4:0]] <= rx;
        endOff <= off[4:0];
        pf <= 1'b0;
      end
      if (st == S_REG && rxGo) mem[off] <= rx;
      if (st == S_PROG && progCnt == 18'(PROG_CYCLES - 1)) begin
        for (int i = 0; i < 32; i++) begin
          if (5'(i) >= spTa[4:0] && 5'(i) <= endOff)
            mem[{spTa[9:5], 5'(i)}] <= spad[i];
        end
        aaFlag <= 1'b1;
      end
      if (st == S_IOW2 && rxGo && rx == ~ioNew) pioOut <= ioNew;
    end
  end

  // identifier with its checksum byte, kept true
  always_ff @(posedge core_clk) begin
    if (!resetn) romCode <= 64'h0000_0000_0000_0000;
    else if (clkEn) romCode <= {swf_crc8(romId), romId};
  end

  // ----------------------------------------
  // rise hold-off glitch filter
  // ----------------------------------------
  // short lows just after the rise are ringing; a long one is a real slot
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      filtHigh <= 1'b0;
      holdCnt <= 8'h00;
      glCnt <= 8'h00;
      slotStart <= 1'b0;
    end else if (clkEn) begin
      slotStart <= 1'b0;
      if (!filtHigh) begin
        glCnt <= 8'h00;
        if (lineHigh) begin
          filtHigh <= 1'b1;
          holdCnt <= 8'(HOLDOFF_CYC);
        end
      end else begin
        if (holdCnt != 8'h00) holdCnt <= 8'(holdCnt - 1'b1);
        if (lineHigh) glCnt <= 8'h00;
        else if (holdCnt == 8'h00 || glCnt == 8'(HOLDOFF_CYC - 1)) begin
          slotStart <= 1'b1;
          filtHigh <= 1'b0;
        end else glCnt <= 8'(glCnt + 1'b1);
      end
    end
  end

  // ----------------------------------------
  // answer queue and registered outputs
  // ----------------------------------------
  swf_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txq (
    .clk(core_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .flush(busReset),
    .inValid(txPush && !busReset),
    .inReady(txRdy),
    .inData(txData),
    .outValid(fifoValid),
    .outReady(txTake && txByte.valid),
    .outData(fifoData)
  );

  // output stage follows the queue head one cycle late
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      txByte <= '0;
      txReady <= 1'b0;
    end else if (clkEn) begin
      txByte.valid <= fifoValid && !(txTake && txByte.valid) && !busReset;
      txByte.data <= fifoData;
      txReady <= (st == S_CMD) || (st == S_TA1) || (st == S_TA2) || (st == S_ES)
        || (st == S_WS) || (st == S_REG) || (st == S_IOW1) || (st == S_IOW2);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn || busReset);

  sequence iowGood;
    st == S_IOW2 && rxGo && rx == ~ioNew;
  endsequence

  crc_inverted_a: assert property (st == S_CRCL |-> txData == ~crc[7:0])
    else $error("checksum low byte not inverted");
  cmd_clears_a: assert property (st == S_CMD && rxGo |=> crc == swf_crc16(16'h0000, $past(rx)))
    else $error("checksum not restarted at command");
  ws_end_a: assert property (st == S_WS && rxGo && off[4:0] == 5'h1F |=> st == S_CRCL)
    else $error("scratch write end not followed by checksum");
  copy_reject_a: assert property (st == S_ES && rxGo && copyProtect |=> st == S_FF)
    else $error("protected copy not rejected");
  iow_good_a: assert property (iowGood |=> st == S_IOWA && pioOut == $past(ioNew))
    else $error("io write not applied");
  iow_bad_a: assert property (st == S_IOW2 && rxGo && rx != ~ioNew |=> st == S_FF && $stable(pioOut))
    else $error("bad io write not rejected");
  ior_block_a: assert property (st == S_IOR && txGo && blkCnt == 6'h1F |=> st == S_CRCL)
    else $error("io read block not closed by checksum");
  ff_loop_a: assert property (st == S_FF |=> st == S_FF)
    else $error("filler loop left without bus reset");
  rom_crc_a: assert property (clkEn |=> romCode[63:56] == swf_crc8($past(romId)))
    else $error("identifier checksum wrong");
  holdoff_a: assert property (filtHigh && holdCnt != 8'h00 && !lineHigh && glCnt < 8'h05 && clkEn |=> !slotStart)
    else $error("short glitch started a slot");
  // a write that never sent data leaves the flag up, so no copy may follow
  copy_partial_a: assert property (st == S_ES && rxGo && pf |=> st == S_FF)
    else $error("partial copy not rejected");
  mem_bad_a: assert property (st == S_TA2 && rxGo && cmd == MEMORY_READ_CMD
    && {rx, ta[7:0]} > MEM_LAST |=> st == S_FF)
    else $error("bad read address not rejected");
endmodule
`default_nettype wire

/* File: design/swf_pkg.sv */
// shared constants, carrier types and checksum functions of the function sequencer
package swf_pkg;
  // command codes
  localparam logic [7:0] SCRATCH_WRITE_CMD = 8'h0F;
  localparam logic [7:0] SCRATCH_READ_CMD = 8'hAA;
  localparam logic [7:0] SCRATCH_COPY_CMD = 8'h55;
  localparam logic [7:0] MEMORY_READ_CMD = 8'hF0;
  localparam logic [7:0] REGISTER_WRITE_CMD = 8'h99;
  localparam logic [7:0] IO_READ_CMD = 8'hF5;
  localparam logic [7:0] IO_WRITE_CMD = 8'h5A;
  // filler and status bytes
  localparam logic [7:0] FILL_FF = 8'hFF;
  localparam logic [7:0] FILL_AA = 8'hAA;
  // address map
  localparam logic [15:0] MEM_LAST = 16'h0225;
  localparam int MEM_WORDS = 550;
  localparam logic [15:0] REG_FIRST = 16'h0223;
  localparam logic [15:0] REG_LAST = 16'h0225;
  localparam logic [4:0] SCRATCH_LAST = 5'h1F;
  localparam logic [5:0] IO_BLOCK_LAST = 6'h1F;
  // ending-offset/status byte layout
  localparam int ES_PF_BIT = 5;
  localparam int ES_AA_BIT = 7;
  // checksum polynomials, bit reversed for lsb-first shifting
  localparam logic [15:0] CRC16_POLY = 16'hA001;
  localparam logic [7:0] CRC8_POLY = 8'h8C;
  localparam logic [15:0] CRC16_INIT = 16'h0000;
  // timing
  localparam int CLK_NS = 50;
  localparam int RISE_HOLDOFF_NS = 1000;
  localparam int HOLDOFF_CYC = (RISE_HOLDOFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAX_PROGRAM_US = 10000;
  localparam int PROG_CYC = MAX_PROGRAM_US * 1000 / CLK_NS;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } swf_byte_t;

  // one byte through the 16-bit checksum, lsb first
  function automatic logic [15:0] swf_crc16(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC16_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // 8-bit identifier checksum over 56 bits, lsb first
  function automatic logic [7:0] swf_crc8(input logic [55:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 56; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC8_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

/* File: tb/swf_master_model.sv */
// byte-level model of the single-wire bus master facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module swf_master_model
  import swf_pkg::*;
(
  input wire logic core_clk,
  input wire swf_byte_t txByte,
  input wire logic txReady,
  output swf_byte_t rxByte,
  output logic txTake
);
  int timeouts = 0;

  // idle master: no byte offered, nothing taken
  initial begin
    rxByte = '0;
    txTake = 1'b0;
  end

  // one write byte, offered once the sequencer listens; no bits are shifted
  // here or in the sequencer, the model hands whole bytes
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    while (txReady !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 200) timeouts++;
    rxByte = '{valid: 1'b1, data: b};
    @(negedge core_clk);
    // released data shows the inverse, never the stale byte
    rxByte = '{valid: 1'b0, data: ~b};
    @(negedge core_clk);
  endtask

  // one read byte; stall gives a slow master, extra idle edge keeps takes apart
  task automatic take(input int stall, output logic [7:0] b);
    int n;
    n = 0;
    repeat (stall) @(negedge core_clk);
    while (txByte.valid !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 200) timeouts++;
    b = txByte.data;
    txTake = 1'b1;
    @(negedge core_clk);
    txTake = 1'b0;
    @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench of the function sequencer with a queue-based model
`timescale 1ns/1ps
`default_nettype none
module tb
  import swf_pkg::*;
;
  localparam int PROG = 20;
  logic core_clk, resetn, clkEn, busReset, txTake, txReady;
  logic lineHigh, slotStart, copyProtect, loop;
  swf_byte_t rxByte, txByte;
  logic [55:0] romId;
  logic [63:0] romCode;
  logic [7:0] pioPins, pioOut, pinVal, got, b, rv;
  logic [7:0] dat [4];
  logic [7:0] q [$];
  int fail_count = 0;
  int n_checks = 0;
  int seed = 54;
  int crc, slots;

  // --------------------------------
  // clock, pins and instances
  // --------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // pins read back the output latch during writes, a random level otherwise
  assign pioPins = loop ? pioOut : pinVal;

  // slot pulses counted for the glitch filter check
  always @(posedge core_clk) begin
    if (slotStart === 1'b1) slots++;
  end

  swf_function_sequencer #(.PROG_CYCLES(PROG)) DUT (
    .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .busReset(busReset),
    .rxByte(rxByte), .txByte(txByte), .txTake(txTake), .txReady(txReady),
    .lineHigh(lineHigh), .slotStart(slotStart), .romId(romId),
    .romCode(romCode), .copyProtect(copyProtect), .pioPins(pioPins),
    .pioOut(pioOut)
  );

  swf_master_model mst (
    .core_clk(core_clk), .txByte(txByte), .txReady(txReady),
    .rxByte(rxByte), .txTake(txTake)
  );

  // --------------------------------
  // reference model and helpers
  // --------------------------------
  function automatic int c16(input int c, input logic [7:0] d);
    int r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = ((r ^ d[i]) & 1) ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] c8(input logic [55:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 56; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ 8'h8C) : (r >> 1);
    end
    return r;
  endfunction

  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // expected answer byte, optionally folded into the running checksum
  task automatic exp_b(input logic [7:0] v, input bit fold);
    q.push_back(v);
    if (fold) crc = c16(crc, v);
  endtask

  // checksum goes out inverted, low byte first
  task automatic exp_crc();
    exp_b(8'(~crc), 1'b0);
    exp_b(8'(~crc >> 8), 1'b0);
  endtask

  task automatic tx(input logic [7:0] v, input bit fold);
    mst.send(v);
    if (fold) crc = c16(crc, v);
  endtask

  // take every queued byte and compare it with the model
  task automatic drain(input int stall);
    while (q.size() > 0) begin
      mst.take(stall, got);
      chk(got, q.pop_front(), "answer byte");
    end
  endtask

  // bus reset ends any loop, then a fresh command with a cleared checksum
  task automatic cmd(input logic [7:0] c);
    busReset = 1'b1;
    @(negedge core_clk);
    busReset = 1'b0;
    @(negedge core_clk);
    crc = 0;
    q.delete();
    tx(c, 1'b1);
  endtask

  task automatic conclude();
    fail_count += mst.timeouts;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the thousand or so cycles the run needs
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  // --------------------------------
  // scenarios
  // --------------------------------
  initial begin
    resetn = 1'b0;
    clkEn = 1'b1;
    busReset = 1'b0;
    lineHigh = 1'b1;
    copyProtect = 1'b0;
    loop = 1'b0;
    pinVal = 8'h00;
    romId = 56'({$random(seed), $random(seed)});
    repeat (10) @(negedge core_clk);
    resetn = 1'b1;
    repeat (2) @(negedge core_clk);
    chk(romCode, {c8(romId), romId}, "identifier");
    // scratch write from offset 1C to the end of the scratchpad
    cmd(SCRATCH_WRITE_CMD);
    tx(8'h1C, 1'b1);
    tx(8'h02, 1'b1);
    for (int i = 0; i < 4; i++) begin
      dat[i] = 8'($random(seed));
      tx(dat[i], 1'b1);
    end
    exp_crc();
    exp_b(FILL_FF, 1'b0);
    exp_b(FILL_FF, 1'b0);
    drain(0);
    // scratch read through the last written byte, slow master
    cmd(SCRATCH_READ_CMD);
    exp_b(8'h1C, 1'b1);
    exp_b(8'h02, 1'b1);
    exp_b(8'h1F, 1'b1);
    for (int i = 0; i < 4; i++) exp_b(dat[i], 1'b1);
    exp_crc();
    exp_b(FILL_FF, 1'b0);
    drain(3);
    // refused copies: wrong address, then protected target
    for (int k = 0; k < 2; k++) begin
      copyProtect = (k == 1);
      cmd(SCRATCH_COPY_CMD);
      tx((k == 0) ? 8'h1D : 8'h1C, 1'b0);
      tx(8'h02, 1'b0);
      tx(8'h1F, 1'b0);
      exp_b(FILL_FF, 1'b0);
      exp_b(FILL_FF, 1'b0);
      drain(0);
    end
    // accepted copy: bus idle for the programming time, then status loop
    copyProtect = 1'b0;
    cmd(SCRATCH_COPY_CMD);
    tx(8'h1C, 1'b0);
    tx(8'h02, 1'b0);
    tx(8'h1F, 1'b0);
    repeat (PROG + 10) @(negedge core_clk);
    repeat (3) exp_b(FILL_AA, 1'b0);
    drain(0);
    // memory read streams copied data to the end of memory, then filler
    cmd(MEMORY_READ_CMD);
    tx(8'h1C, 1'b0);
    tx(8'h02, 1'b0);
    for (int i = 0; i < 4; i++) exp_b(dat[i], 1'b0);
    drain(0);
    repeat (6) mst.take(0, got);
    exp_b(FILL_FF, 1'b0);
    drain(0);
    // register write at the last register, read back, then bad targets
    rv = 8'($random(seed));
    cmd(REGISTER_WRITE_CMD);
    tx(8'h25, 1'b0);
    tx(8'h02, 1'b0);
    tx(rv, 1'b0);
    exp_b(FILL_FF, 1'b0);
    drain(0);
    cmd(MEMORY_READ_CMD);
    tx(8'h25, 1'b0);
    tx(8'h02, 1'b0);
    exp_b(rv, 1'b0);
    exp_b(FILL_FF, 1'b0);
    drain(0);
    for (int k = 0; k < 2; k++) begin
      cmd((k == 0) ? REGISTER_WRITE_CMD : MEMORY_READ_CMD);
      tx((k == 0) ? 8'h22 : 8'h26, 1'b0);
      tx(8'h02, 1'b0);
      exp_b(FILL_FF, 1'b0);
      exp_b(FILL_FF, 1'b0);
      drain(0);
    end
    // copy after a write with no data: status 3C carries the partial flag
    cmd(SCRATCH_WRITE_CMD);
    tx(8'h1C, 1'b0);
    tx(8'h02, 1'b0);
    cmd(SCRATCH_COPY_CMD);
    tx(8'h1C, 1'b0);
    tx(8'h02, 1'b0);
    tx(8'h3C, 1'b0);
    exp_b(FILL_FF, 1'b0);
    drain(0);
    // io write, two good pairs then a bad complement
    loop = 1'b1;
    cmd(IO_WRITE_CMD);
    for (int k = 0; k < 2; k++) begin
      b = 8'($random(seed));
      tx(b, 1'b0);
      tx(~b, 1'b0);
      exp_b(FILL_AA, 1'b0);
      exp_b(b, 1'b0);
      drain(0);
      chk(pioOut, b, "pin latch");
    end
    cmd(IO_WRITE_CMD);
    tx(~b, 1'b0);
    // repeating the first byte can never be its complement, whatever b is
    tx(~b, 1'b0);
    exp_b(FILL_FF, 1'b0);
    exp_b(FILL_FF, 1'b0);
    drain(0);
    chk(pioOut, b, "latch kept");
    // io read, first block with a stalled master so the fifo fills
    loop = 1'b0;
    pinVal = 8'($random(seed));
    cmd(IO_READ_CMD);
    for (int blk = 0; blk < 3; blk++) begin
      if (blk > 0) crc = 0;
      repeat (32) exp_b(pinVal, 1'b1);
      exp_crc();
      drain((blk == 0) ? 12 : 0);
    end
    // glitch filter: low inside hold-off ignored, late low starts a slot
    slots = 0;
    lineHigh = 1'b0;
    repeat (2) @(negedge core_clk);
    lineHigh = 1'b1;
    repeat (5) @(negedge core_clk);
    lineHigh = 1'b0;
    repeat (5) @(negedge core_clk);
    lineHigh = 1'b1;
    repeat (20) @(negedge core_clk);
    lineHigh = 1'b0;
    repeat (3) @(negedge core_clk);
    lineHigh = 1'b1;
    repeat (5) @(negedge core_clk);
    chk(64'(slots), 64'd2, "slot count");
    // frozen clock enable: a late low must not start a slot
    repeat (20) @(negedge core_clk);
    clkEn = 1'b0;
    lineHigh = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(64'(slots), 64'd2, "frozen filter");
    lineHigh = 1'b1;
    clkEn = 1'b1;
    conclude();
  end
endmodule
`default_nettype wire
